// ==== rtl/fbl_pkg.sv ====
/*
 * Constants, state codes and phase codes for the flash boot image loader.
 * Assumes a single 10 MHz tile clock and a one-word OTP read port.
 */
package fbl_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int BOOT_DELAY_US = 15;
	// Least wait, so the count rounds up to whole cycles.
	localparam int BOOT_DELAY_CYC_I = (BOOT_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] BOOT_DELAY_CYC = BOOT_DELAY_CYC_I[7:0];

	// ************************************************************
	// Image format and checksum
	// ************************************************************
	localparam logic [31:0] CRC_POLY = 32'hEDB88320;
	localparam logic [31:0] CRC_PRESET = 32'hFFFFFFFF;
	localparam logic [31:0] NO_CRC_MARKER = 32'h0D15AB1E;

	// ************************************************************
	// Security register, OTP and RAM
	// ************************************************************
	localparam int SEC_BOOT_BIT = 5;
	localparam int OTP_AW = 11;
	localparam logic [OTP_AW-1:0] OTP_SEC_ADDR = 11'h7FF;
	localparam logic [OTP_AW-1:0] OTP_IMAGE_ADDR = 11'h000;
	localparam int RAM_AW = 17;
	localparam logic [RAM_AW-1:0] RAM_BASE = 17'h00000;

	// ************************************************************
	// Flash read header
	// ************************************************************
	localparam logic [7:0] FLASH_READ_CMD = 8'h03;
	localparam logic [23:0] FLASH_IMAGE_ADDR = 24'h000000;
	localparam logic [5:0] FLASH_HDR_BITS = 6'h20;
	localparam logic [5:0] BYTE_LAST_BIT = 6'h07;
	localparam logic [2:0] OTP_WORD_BYTES = 3'h4;

	typedef enum logic [2:0] {
		ST_DELAY = 3'b000,
		ST_SEC = 3'b001,
		ST_SRC = 3'b011,
		ST_FCMD = 3'b010,
		ST_STREAM = 3'b110,
		ST_CHECK = 3'b111,
		ST_RUN = 3'b101,
		ST_FAIL = 3'b100
	} fbl_state_t;

	typedef enum logic [1:0] {
		PH_SIZE = 2'b00,
		PH_PROG = 2'b01,
		PH_CRC = 2'b11
	} fbl_phase_t;

endpackage

// ==== rtl/fbl_crc_byte.sv ====
/*
 * Byte-wide reflected CRC-32 register.
 * Assumes the caller raises init before the first byte and en once per byte.
 */
`timescale 1ns/1ns
module fbl_crc_byte (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic init_in,
	input wire logic en_in,
	input wire logic [7:0] byte_in,
	output logic [31:0] crc_out
);
	import fbl_pkg::*;

	logic [31:0] crc_q;
	logic [31:0] crc_d;
	logic [31:0] chain [0:8];

	assign chain[0] = crc_q;

	// Bit zero of the byte enters first.
	generate
		for (genvar i = 0; i < 8; i++) begin : g_bit
			assign chain[i+1] = (chain[i][0] ^ byte_in[i]) ? ({1'b0, chain[i][31:1]} ^ CRC_POLY) :
				{1'b0, chain[i][31:1]};
		end
	endgenerate

	always_comb begin
		crc_d = crc_q;
		if (init_in) begin
			crc_d = CRC_PRESET;
		end else if (en_in) begin
			crc_d = chain[8];
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			crc_q <= CRC_PRESET;
		end else begin
			crc_q <= crc_d;
		end
	end

	assign crc_out = crc_q;

	crc_preset_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		init_in |=> crc_out == CRC_PRESET) else $error("CRC not preset after init.");

	crc_lsb_first_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		en_in && !init_in && byte_in == 8'h01 && crc_q == CRC_PRESET |=> crc_out == 32'h5AFA20E4)
		else $error("CRC did not take bit zero first.");

endmodule // fbl_crc_byte

// ==== rtl/fbl_loader.sv ====
/*
 * Boot loader for one processor tile: picks OTP or the embedded flash,
 * copies a length-prefixed image into RAM, checks its CRC and starts it.
 * Assumes OTP answers a read pulse with one valid pulse, and the flash
 * accepts a plain serial read on the tile 0 pins.
 */
`timescale 1ns/1ns

// What this block does
// - Pull-downs on every general-purpose pin while chip reset is held.
// - Wait the internal reset time after release before booting starts.
// - Security bit five set boots from OTP, clear boots from flash.
// - Flash image is fetched over the tile 0 port pins.
// - Image opens with a word count, then four bytes per word.
// - Trailing word is the CRC, or a marker that skips the check.
// - Size and CRC words are assembled least significant byte first.
// - Program bytes are written into RAM from the lowest address.
// - Execution starts at the lowest RAM address.
// - CRC covers size word and program, never the trailing word.
// - CRC uses the reflected polynomial EDB88320.
// - CRC preset to ones; the inverted residue is compared.
// - OTP boot reads the image from OTP address zero.
// - Security register is read from OTP before choosing the source.
module fbl_loader (
	input wire logic clk_in,
	input wire logic rst_n_in,
	output logic gpio_pulldown_out,
	output logic otp_rd_out,
	output logic [fbl_pkg::OTP_AW-1:0] otp_addr_out,
	input wire logic otp_valid_in,
	input wire logic [31:0] otp_data_in,
	output logic flash_cs_n_out,
	output logic flash_sclk_out,
	output logic flash_mosi_out,
	input wire logic flash_miso_in,
	output logic ram_we_out,
	output logic [fbl_pkg::RAM_AW-1:0] ram_addr_out,
	output logic [7:0] ram_data_out,
	output logic run_out,
	output logic [fbl_pkg::RAM_AW-1:0] exec_addr_out,
	output logic fail_out,
	output logic boot_otp_out
);
	import fbl_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	fbl_state_t state_q, state_d;
	fbl_phase_t phase_q, phase_d;
	logic [7:0] delay_q, delay_d;
	logic [31:0] sec_q, sec_d;
	logic src_otp_q, src_otp_d;
	logic otp_rd_q, otp_rd_d;
	logic [OTP_AW-1:0] otp_addr_q, otp_addr_d;
	logic otp_pend_q, otp_pend_d;
	logic [31:0] word_q, word_d;
	logic [2:0] word_cnt_q, word_cnt_d;
	logic sclk_q, sclk_d;
	logic cs_n_q, cs_n_d;
	logic [31:0] sr_q, sr_d;
	logic [5:0] bit_q, bit_d;
	logic [1:0] pcnt_q, pcnt_d;
	logic [31:0] size_q, size_d;
	logic [31:0] stored_q, stored_d;
	logic [31:0] addr_q, addr_d;
	logic ram_we_q, ram_we_d;
	logic [RAM_AW-1:0] ram_addr_q, ram_addr_d;
	logic [7:0] ram_data_q, ram_data_d;
	logic run_q, run_d;
	logic fail_q, fail_d;
	logic pd_q;
	logic byte_stb;
	logic [7:0] byte_val;
	logic [31:0] crc_val;
	logic crc_init;
	logic crc_en;

	// Trailing word stays out of the sum.
	assign crc_init = (state_q == ST_SRC);
	assign crc_en = byte_stb && (phase_q != PH_CRC);

	fbl_crc_byte u_crc (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.init_in(crc_init),
		.en_in(crc_en),
		.byte_in(byte_val),
		.crc_out(crc_val)
	);

	// ************************************************************
	// Sequencer, byte sources and image parser
	// ************************************************************
	always_comb begin
		state_d = state_q;
		phase_d = phase_q;
		delay_d = delay_q;
		sec_d = sec_q;
		src_otp_d = src_otp_q;
		otp_rd_d = 1'b0;
		otp_addr_d = otp_addr_q;
		otp_pend_d = otp_pend_q;
		word_d = word_q;
		word_cnt_d = word_cnt_q;
		sclk_d = sclk_q;
		cs_n_d = cs_n_q;
		sr_d = sr_q;
		bit_d = bit_q;
		pcnt_d = pcnt_q;
		size_d = size_q;
		stored_d = stored_q;
		addr_d = addr_q;
		ram_we_d = 1'b0;
		ram_addr_d = ram_addr_q;
		ram_data_d = ram_data_q;
		run_d = run_q;
		fail_d = fail_q;
		byte_stb = 1'b0;
		byte_val = 8'h00;
		unique case (state_q)
			ST_DELAY: begin
				if (delay_q == BOOT_DELAY_CYC - 8'h01) begin
					state_d = ST_SEC;
					otp_rd_d = 1'b1;
					otp_addr_d = OTP_SEC_ADDR;
				end else begin
					delay_d = delay_q + 8'h01;
				end
			end
			ST_SEC: begin
				if (otp_valid_in) begin
					sec_d = otp_data_in;
					state_d = ST_SRC;
				end
			end
			ST_SRC: begin
				phase_d = PH_SIZE;
				pcnt_d = 2'h0;
				addr_d = 32'h00000000;
				src_otp_d = sec_q[SEC_BOOT_BIT];
				if (sec_q[SEC_BOOT_BIT]) begin
					// Image read from OTP word zero.
					state_d = ST_STREAM;
					otp_rd_d = 1'b1;
					otp_addr_d = OTP_IMAGE_ADDR;
					otp_pend_d = 1'b1;
					word_cnt_d = 3'h0;
				end else begin
					state_d = ST_FCMD;
					cs_n_d = 1'b0;
					sclk_d = 1'b0;
					sr_d = {FLASH_READ_CMD, FLASH_IMAGE_ADDR};
					bit_d = 6'h00;
				end
			end
			ST_FCMD: begin
				sclk_d = ~sclk_q;
				if (!sclk_q) begin
					bit_d = bit_q + 6'h01;
				end else if (bit_q == FLASH_HDR_BITS) begin
					state_d = ST_STREAM;
					bit_d = 6'h00;
				end else begin
					sr_d = {sr_q[30:0], 1'b0};
				end
			end
			ST_STREAM: begin
				if (src_otp_q) begin
					if (word_cnt_q != 3'h0) begin
						byte_stb = 1'b1;
						byte_val = word_q[7:0];
						word_d = {8'h00, word_q[31:8]};
						word_cnt_d = word_cnt_q - 3'h1;
					end else if (otp_pend_q) begin
						if (otp_valid_in) begin
							word_d = otp_data_in;
							word_cnt_d = OTP_WORD_BYTES;
							otp_pend_d = 1'b0;
						end
					end else begin
						otp_rd_d = 1'b1;
						otp_addr_d = otp_addr_q + 11'h001;
						otp_pend_d = 1'b1;
					end
				end else begin
					// Sampling on the rising edge; the flash shifts on the falling one.
					sclk_d = ~sclk_q;
					if (!sclk_q) begin
						sr_d = {sr_q[30:0], flash_miso_in};
						if (bit_q == BYTE_LAST_BIT) begin
							byte_stb = 1'b1;
							byte_val = {sr_q[6:0], flash_miso_in};
							bit_d = 6'h00;
						end else begin
							bit_d = bit_q + 6'h01;
						end
					end
				end
			end
			ST_CHECK: begin
				if (stored_q == NO_CRC_MARKER || stored_q == ~crc_val) begin
					state_d = ST_RUN;
					run_d = 1'b1;
				end else begin
					state_d = ST_FAIL;
					fail_d = 1'b1;
				end
			end
			ST_RUN: begin
				run_d = 1'b1;
			end
			ST_FAIL: begin
				fail_d = 1'b1;
			end
		endcase
		if (byte_stb) begin
			unique case (phase_q)
				PH_SIZE: begin
					size_d[8*pcnt_q +: 8] = byte_val;
					pcnt_d = pcnt_q + 2'h1;
					if (pcnt_q == 2'h3) begin
						phase_d = ({byte_val, size_q[23:0]} == 32'h00000000) ? PH_CRC : PH_PROG;
					end
				end
				PH_PROG: begin
					// Bytes into RAM from the bottom.
					ram_we_d = 1'b1;
					ram_addr_d = RAM_BASE + addr_q[RAM_AW-1:0];
					ram_data_d = byte_val;
					addr_d = addr_q + 32'h00000001;
					if (addr_q + 32'h00000001 == {size_q[29:0], 2'b00}) begin
						phase_d = PH_CRC;
					end
				end
				PH_CRC: begin
					stored_d[8*pcnt_q +: 8] = byte_val;
					pcnt_d = pcnt_q + 2'h1;
					if (pcnt_q == 2'h3) begin
						state_d = ST_CHECK;
						cs_n_d = 1'b1;
						sclk_d = 1'b0;
					end
				end
				default: begin
					phase_d = PH_SIZE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_q <= ST_DELAY;
			phase_q <= PH_SIZE;
			delay_q <= 8'h00;
			sec_q <= 32'h00000000;
			src_otp_q <= 1'b0;
			otp_rd_q <= 1'b0;
			otp_addr_q <= OTP_IMAGE_ADDR;
			otp_pend_q <= 1'b0;
			word_q <= 32'h00000000;
			word_cnt_q <= 3'h0;
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
			sr_q <= 32'h00000000;
			bit_q <= 6'h00;
			pcnt_q <= 2'h0;
			size_q <= 32'h00000000;
			stored_q <= 32'h00000000;
			addr_q <= 32'h00000000;
			ram_we_q <= 1'b0;
			ram_addr_q <= RAM_BASE;
			ram_data_q <= 8'h00;
			run_q <= 1'b0;
			fail_q <= 1'b0;
			pd_q <= 1'b1;
		end else begin
			state_q <= state_d;
			phase_q <= phase_d;
			delay_q <= delay_d;
			sec_q <= sec_d;
			src_otp_q <= src_otp_d;
			otp_rd_q <= otp_rd_d;
			otp_addr_q <= otp_addr_d;
			otp_pend_q <= otp_pend_d;
			word_q <= word_d;
			word_cnt_q <= word_cnt_d;
			sclk_q <= sclk_d;
			cs_n_q <= cs_n_d;
			sr_q <= sr_d;
			bit_q <= bit_d;
			pcnt_q <= pcnt_d;
			size_q <= size_d;
			stored_q <= stored_d;
			addr_q <= addr_d;
			ram_we_q <= ram_we_d;
			ram_addr_q <= ram_addr_d;
			ram_data_q <= ram_data_d;
			run_q <= run_d;
			fail_q <= fail_d;
			pd_q <= 1'b0;
		end
	end

	assign gpio_pulldown_out = pd_q;
	assign otp_rd_out = otp_rd_q;
	assign otp_addr_out = otp_addr_q;
	assign flash_cs_n_out = cs_n_q;
	assign flash_sclk_out = sclk_q;
	assign flash_mosi_out = sr_q[31];
	assign ram_we_out = ram_we_q;
	assign ram_addr_out = ram_addr_q;
	assign ram_data_out = ram_data_q;
	assign run_out = run_q;
	// Start address is the RAM bottom, ram_addr_q masked by RAM_BASE.
	assign exec_addr_out = ram_addr_q & RAM_BASE;
	assign fail_out = fail_q;
	assign boot_otp_out = src_otp_q;

	// ************************************************************
	// Checks
	// ************************************************************
	pulldown_rst_a: assert property (@(posedge clk_in)
		!rst_n_in |=> gpio_pulldown_out) else $error("Pull-down not enabled in reset.");

	boot_delay_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state_q == ST_SEC && $past(state_q) == ST_DELAY |-> $past(delay_q) == BOOT_DELAY_CYC - 8'h01)
		else $error("Boot began before the reset wait ended.");

	src_select_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state_q == ST_SRC |=> boot_otp_out == $past(sec_q[SEC_BOOT_BIT]))
		else $error("Boot source does not follow the security bit.");

	flash_select_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state_q == ST_SRC && !sec_q[SEC_BOOT_BIT] |=> !flash_cs_n_out ##1 flash_sclk_out)
		else $error("Flash not selected for flash boot.");

	marker_skip_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state_q == ST_CHECK && stored_q == NO_CRC_MARKER |=> run_out && !fail_out)
		else $error("Marker did not skip the check.");

	size_lsb_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		byte_stb && phase_q == PH_SIZE && pcnt_q == 2'h0 |=> size_q[7:0] == $past(byte_val))
		else $error("Size word not assembled low byte first.");

	ram_base_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		byte_stb && phase_q == PH_PROG && addr_q == 32'h00000000 |=> ram_we_out && ram_addr_out == RAM_BASE)
		else $error("First program byte not at RAM bottom.");

	exec_addr_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		run_out |-> exec_addr_out == RAM_BASE) else $error("Start address is not RAM bottom.");

	crc_excl_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		byte_stb && phase_q == PH_CRC |=> $stable(crc_val)) else $error("Trailing word entered the CRC.");

	otp_base_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state_q == ST_SRC && sec_q[SEC_BOOT_BIT] |=> otp_rd_out && otp_addr_out == OTP_IMAGE_ADDR)
		else $error("OTP image read did not start at zero.");

	crc_fail_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state_q == ST_CHECK && stored_q != NO_CRC_MARKER && stored_q != ~crc_val |=> (fail_out && !run_out) [*2])
		else $error("Bad CRC did not block the start.");

endmodule // fbl_loader

// ==== testbench/fbl_flash_model.sv ====
/*
 * Serial flash holding the boot image, seen from the tile 0 pins.
 * Assumes mode 0 timing: bits are taken on sclk rise and changed on sclk fall.
 */
`timescale 1ns/1ns
module fbl_flash_model (
	input wire logic flash_cs_n_in,
	input wire logic flash_sclk_in,
	input wire logic flash_mosi_in,
	output logic flash_miso_out
);
	logic [7:0] mem [0:63];
	logic [31:0] hdr;
	int cnt;
	initial begin
		flash_miso_out = 1'b0;
		hdr = 32'h0;
		cnt = 0;
	end
	always @(posedge flash_sclk_in) begin
		if (!flash_cs_n_in) begin
			if (cnt < 32) hdr = {hdr[30:0], flash_mosi_in};
			cnt = cnt + 1;
		end
	end
	// Outside the data phase the line toggles, so a stale bit never looks valid.
	always @(negedge flash_sclk_in) begin
		if (!flash_cs_n_in && cnt >= 32) flash_miso_out = mem[(cnt - 32) / 8][7 - ((cnt - 32) % 8)];
		else flash_miso_out = ~flash_miso_out;
	end
	always @(posedge flash_cs_n_in) begin
		cnt = 0;
		flash_miso_out = ~flash_miso_out;
	end
endmodule // fbl_flash_model

// ==== testbench/fbl_loader_bench.sv ====
/*
 * Self-checking bench for the boot loader: OTP and flash boots, CRC cases.
 * Assumes the flash model file and the design package are compiled first.
 */
`timescale 1ns/1ns
module fbl_loader_bench;
	import fbl_pkg::*;
	logic clk_in, rst_n_in, otp_valid_in, flash_miso_in;
	logic [31:0] otp_data_in, sec;
	logic gpio_pulldown_out, otp_rd_out, flash_cs_n_out, flash_sclk_out, flash_mosi_out;
	logic ram_we_out, run_out, fail_out, boot_otp_out;
	logic [OTP_AW-1:0] otp_addr_out;
	logic [RAM_AW-1:0] ram_addr_out, exec_addr_out;
	logic [7:0] ram_data_out;
	int miscompares, tests_run, cycles, otp_wait;
	logic [7:0] img [$];
	logic [RAM_AW-1:0] ram_a [$];
	logic [7:0] ram_d [$];
	logic [OTP_AW-1:0] otp_seen [$];

	fbl_loader u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .gpio_pulldown_out(gpio_pulldown_out),
		.otp_rd_out(otp_rd_out), .otp_addr_out(otp_addr_out), .otp_valid_in(otp_valid_in),
		.otp_data_in(otp_data_in), .flash_cs_n_out(flash_cs_n_out), .flash_sclk_out(flash_sclk_out),
		.flash_mosi_out(flash_mosi_out), .flash_miso_in(flash_miso_in), .ram_we_out(ram_we_out),
		.ram_addr_out(ram_addr_out), .ram_data_out(ram_data_out), .run_out(run_out),
		.exec_addr_out(exec_addr_out), .fail_out(fail_out), .boot_otp_out(boot_otp_out));
	fbl_flash_model u_flash (.flash_cs_n_in(flash_cs_n_out), .flash_sclk_in(flash_sclk_out),
		.flash_mosi_in(flash_mosi_out), .flash_miso_out(flash_miso_in));

	// ************************************************************
	// Clock, OTP responder, RAM monitor, timeout
	// ************************************************************
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	function automatic logic [31:0] otp_word(input logic [OTP_AW-1:0] a);
		logic [31:0] w;
		w = 32'h0;
		if (a == 11'h7FF) return sec;
		for (int b = 0; b < 4; b++) if (4 * a + b < img.size()) w[8*b +: 8] = img[4*a + b];
		return w;
	endfunction
	always @(posedge clk_in) begin
		if (!rst_n_in) otp_wait <= 0;
		else if (otp_rd_out === 1'b1) begin
			otp_seen.push_back(otp_addr_out);
			otp_wait <= 2;
		end else if (otp_wait != 0) otp_wait <= otp_wait - 1;
		otp_valid_in <= rst_n_in && otp_wait == 1;
		if (rst_n_in && otp_wait == 1) otp_data_in <= otp_word(otp_addr_out);
		else otp_data_in <= ~otp_data_in;
		if (ram_we_out === 1'b1) begin
			ram_a.push_back(ram_addr_out);
			ram_d.push_back(ram_data_out);
		end
		cycles++;
		if (cycles >= 40000) begin
			miscompares++;
			final_report();
		end
	end

	// ************************************************************
	// Compare and image helpers
	// ************************************************************
	task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [31:0] crc_of(input int n);
		logic [31:0] c;
		c = 32'hFFFFFFFF;
		for (int i = 0; i < n; i++) begin
			c = c ^ {24'h0, img[i]};
			for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
		end
		return ~c;
	endfunction
	// Mode 0 good checksum, 1 skip marker, 2 corrupted checksum.
	task automatic boot(input logic sec5, input int words, input int mode);
		logic [31:0] t;
		int n;
		img.delete();
		for (int b = 0; b < 4; b++) img.push_back(8'(words >> (8 * b)));
		for (int i = 0; i < 4 * words; i++) img.push_back(8'(i * 37 + 5));
		t = (mode == 1) ? 32'h0D15AB1E : crc_of(img.size()) ^ ((mode == 2) ? 32'h1 : 32'h0);
		for (int b = 0; b < 4; b++) img.push_back(t[8*b +: 8]);
		for (int i = 0; i < img.size(); i++) u_flash.mem[i] = img[i];
		sec = {26'h0, sec5, 5'h0};
		ram_a.delete();
		ram_d.delete();
		otp_seen.delete();
		rst_n_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		check32("pulldown in reset", 32'h1, {31'h0, gpio_pulldown_out});
		rst_n_in <= 1'b1;
		n = 0;
		while (otp_rd_out !== 1'b1 && n < 2000) begin
			@(posedge clk_in);
			n++;
			if (n == 3) check32("pulldown released", 32'h0, {31'h0, gpio_pulldown_out});
		end
		check32("boot delay ok", 32'h1, {31'h0, n >= 150 && n <= 1500});
		n = 0;
		while (run_out !== 1'b1 && fail_out !== 1'b1 && n < 9000) begin
			@(posedge clk_in);
			n++;
		end
		repeat (5) @(posedge clk_in);
		check32("boot source", {31'h0, sec5}, {31'h0, boot_otp_out});
		check32("security read", 32'h7FF, 32'(otp_seen[0]));
		check32("otp reads", sec5 ? 32'(words + 3) : 32'h1, 32'(otp_seen.size()));
		if (sec5) check32("otp image start", 32'h0, 32'(otp_seen[1]));
		else check32("flash header", 32'h03000000, u_flash.hdr);
		check32("ram writes", 32'(4 * words), 32'(ram_a.size()));
		for (int i = 0; i < ram_a.size(); i++) begin
			check32("ram address", 32'(i), 32'(ram_a[i]));
			check32("ram data", {24'h0, img[4 + i]}, {24'h0, ram_d[i]});
		end
		check32("run", {31'h0, mode != 2}, {31'h0, run_out});
		check32("fail", {31'h0, mode == 2}, {31'h0, fail_out});
		if (mode != 2) check32("exec address", 32'h0, 32'(exec_addr_out));
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic test_otp_crc();
		boot(1'b1, 3, 0);
	endtask
	task automatic test_otp_marker();
		boot(1'b1, 1, 1);
	endtask
	task automatic test_flash_crc();
		boot(1'b0, 5, 0);
	endtask
	task automatic test_flash_marker();
		boot(1'b0, 2, 1);
	endtask
	task automatic test_flash_bad_crc();
		boot(1'b0, 2, 2);
	endtask
	task automatic test_flash_empty();
		boot(1'b0, 0, 0);
	endtask
	task automatic test_otp_bad_crc();
		boot(1'b1, 2, 2);
	endtask

	task automatic final_report();
		if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		rst_n_in = 1'b0;
		otp_valid_in = 1'b0;
		otp_data_in = 32'h0;
		sec = 32'h0;
		otp_wait = 0;
		miscompares = 0;
		tests_run = 0;
		cycles = 0;
		@(posedge clk_in);
		test_otp_crc();
		test_otp_marker();
		test_flash_crc();
		test_flash_marker();
		test_flash_bad_crc();
		test_flash_empty();
		test_otp_bad_crc();
		final_report();
	end
endmodule // fbl_loader_bench
